// ==== sram_bus_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "sram_bus_defs.svh"

// Contract
// - unselected strobe cycle deselects and tri-states data pins.
// - sleep request high: power down, tri-state, ignore all else.
// - processor strobe low with chip selected starts a read burst.
// - controller strobe, processor strobe high, write low: write burst.
// - controller strobe, processor strobe high, write high: read burst.
// - continue with advance low and write high reads next address.
// - continue with advance low and write low writes next address.
// - continue with advance high holds address, reads or writes it.
// - combined write active on global write or byte write plus lane.
// - byte write writes only low lanes with parity; global writes all.
// - any lane combination allowed; unselected bytes stay unchanged.
// - writes only after processor strobe cycle or with controller one.
// - during writes output enable is masked and drivers stay off.
// - data drive follows cycle type combined with output enable.
// - reads drive data only with output enable low and chip selected.
// - two-bit wrapping burst counter, interleaved or linear order.
// - processor strobe write takes two clocks, controller one.
// - read data one edge after address; first data edge of a start from deselect tri-stated.
module sram_bus_ctrl
#(
  parameter int LANES  = `LANES_DEF,
  parameter int ADDR_W = `ADDR_W_DEF
)
(
  input  wire logic                    SYS_CLK,
  input  wire logic                    RST,
  input  wire logic                    CLK_EN,
  input  wire logic                    SLEEP_REQUEST,
  input  wire logic                    OUTPUT_ENABLE_N,
  input  wire logic                    BURST_MODE,
  input  wire logic                    PIPELINE_CHIP_SELECT_N,
  input  wire logic                    DEPTH_SELECT_HIGH,
  input  wire logic                    DEPTH_SELECT_LOW_N,
  input  wire logic                    PROCESSOR_ADDR_STROBE_N,
  input  wire logic                    CONTROLLER_ADDR_STROBE_N,
  input  wire logic                    BURST_ADVANCE_N,
  input  wire logic                    GLOBAL_WRITE_N,
  input  wire logic                    BYTE_WRITE_ENABLE_N,
  input  wire logic [LANES-1:0]        BYTE_LANE_WRITE_N,
  input  wire logic [ADDR_W-1:0]       ADDR,
  input  wire logic [LANES*`LANE_W-1:0] DQ_IN,
  output var  logic [LANES*`LANE_W-1:0] DQ_OUT,
  output var  logic                    DQ_OE,
  output var  sram_bus_pkg::cycle_t    CYCLE_TYPE,
  output var  logic                    SLEEP_ACTIVE
);
  import sram_bus_pkg::*;

  localparam int DW = LANES * `LANE_W;

  // --------------------------------------------------------------------
  // asynchronous pins: two flops before any use
  // --------------------------------------------------------------------
  logic sleep_m_q;
  logic sleep_s_q;
  logic oe_n_m_q;
  logic oe_n_s_q;
  logic mode_m_q;
  logic mode_s_q;

  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      sleep_m_q <= `SYNC_RST;
      sleep_s_q <= `SYNC_RST;
      oe_n_m_q  <= `OE_N_SYNC_RST;
      oe_n_s_q  <= `OE_N_SYNC_RST;
      mode_m_q  <= `SYNC_RST;
      mode_s_q  <= `SYNC_RST;
    end
    else if (CLK_EN)
    begin
      sleep_m_q <= SLEEP_REQUEST;
      sleep_s_q <= sleep_m_q;
      oe_n_m_q  <= OUTPUT_ENABLE_N;
      oe_n_s_q  <= oe_n_m_q;
      mode_m_q  <= BURST_MODE;
      mode_s_q  <= mode_m_q;
    end
  end

  // --------------------------------------------------------------------
  // write decode
  // --------------------------------------------------------------------
  function automatic logic combined_write(input logic gw_n,
                                          input logic bwe_n,
                                          input logic [LANES-1:0] bw_n);
    combined_write = !gw_n || (!bwe_n && !(&bw_n));
  endfunction : combined_write

  function automatic logic [LANES-1:0] lane_mask(input logic gw_n,
                                                 input logic bwe_n,
                                                 input logic [LANES-1:0] bw_n);
    if (!gw_n)
      lane_mask = '1;
    else if (!bwe_n)
      lane_mask = ~bw_n;
    else
      lane_mask = '0;
  endfunction : lane_mask

  function automatic logic is_start(input cycle_t c);
    is_start = (c == CYC_READ_START) || (c == CYC_WRITE_START);
  endfunction : is_start

  function automatic logic is_write(input cycle_t c);
    is_write = (c == CYC_WRITE_START) || (c == CYC_WRITE_NEXT)
            || (c == CYC_WRITE_HOLD);
  endfunction : is_write

  logic                 sel_now;
  logic                 wr_now;
  logic [LANES-1:0]     mask_now;
  cycle_t               cyc_d;
  cycle_t               cyc_q;
  logic                 sel_d;
  logic                 sel_q;
  logic [ADDR_W-1:0]    eff_addr;
  logic [ADDR_W-3:0]    hi_d;
  logic [ADDR_W-3:0]    hi_q;
  burst_if              bif ();

  // --------------------------------------------------------------------
  // cycle decode at the clock edge
  // --------------------------------------------------------------------
  always_comb
  begin
    sel_now  = !PIPELINE_CHIP_SELECT_N && DEPTH_SELECT_HIGH
            && !DEPTH_SELECT_LOW_N;
    wr_now   = combined_write(GLOBAL_WRITE_N, BYTE_WRITE_ENABLE_N,
                              BYTE_LANE_WRITE_N);
    mask_now = lane_mask(GLOBAL_WRITE_N, BYTE_WRITE_ENABLE_N,
                         BYTE_LANE_WRITE_N);
    if (sleep_s_q)
      cyc_d = CYC_SLEEP;
    else if (!PROCESSOR_ADDR_STROBE_N && !PIPELINE_CHIP_SELECT_N)
      // write controls ignored here; a write follows on the next clock
      cyc_d = sel_now ? CYC_READ_START : CYC_DESELECT;
    else if (!CONTROLLER_ADDR_STROBE_N)
      if (!sel_now)
        cyc_d = CYC_DESELECT;
      else
        cyc_d = wr_now ? CYC_WRITE_START : CYC_READ_START;
    else if (!sel_q)
      cyc_d = CYC_IDLE;
    else if (!BURST_ADVANCE_N)
      cyc_d = wr_now ? CYC_WRITE_NEXT : CYC_READ_NEXT;
    else
      cyc_d = wr_now ? CYC_WRITE_HOLD : CYC_READ_HOLD;
    case (cyc_d)
      CYC_READ_START, CYC_WRITE_START: sel_d = 1'b1;
      CYC_DESELECT, CYC_SLEEP:         sel_d = 1'b0;
      default:                         sel_d = sel_q;
    endcase
    hi_d           = is_start(cyc_d) ? ADDR[ADDR_W-1:2] : hi_q;
    bif.en         = CLK_EN;
    bif.load       = is_start(cyc_d);
    bif.advance    = (cyc_d == CYC_READ_NEXT) || (cyc_d == CYC_WRITE_NEXT);
    bif.interleave = mode_s_q;
    bif.ext_low    = ADDR[1:0];
    eff_addr       = {hi_d, bif.eff_low};
  end

  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      cyc_q <= CYC_IDLE;
      sel_q <= 1'b0;
      hi_q  <= '0;
    end
    else if (CLK_EN)
    begin
      cyc_q <= cyc_d;
      sel_q <= sel_d;
      hi_q  <= hi_d;
    end
  end

  burst_counter u_burst (
    .SYS_CLK (SYS_CLK),
    .RST     (RST),
    .bif     (bif)
  );

  // --------------------------------------------------------------------
  // storage, lane-wise writes
  // --------------------------------------------------------------------
  logic [DW-1:0] mem [2**ADDR_W];

  always_ff @(posedge SYS_CLK)
  begin
    if (CLK_EN && is_write(cyc_d))
      for (int i = 0; i < LANES; i++)
        if (mask_now[i])
          mem[eff_addr][i*`LANE_W +: `LANE_W] <= DQ_IN[i*`LANE_W +: `LANE_W];
  end

  // --------------------------------------------------------------------
  // read pipeline and output drivers
  // --------------------------------------------------------------------
  logic              rd_d;
  logic              rd_q;
  logic              first_d;
  logic              first_q;
  logic [ADDR_W-1:0] rd_addr_q;
  logic [DW-1:0]     dout_d;
  logic              oe_d;

  always_comb
  begin
    rd_d    = !is_write(cyc_d) && (sel_d || is_start(cyc_d))
           && (cyc_d != CYC_IDLE) && (cyc_d != CYC_SLEEP);
    // emerging from deselect: the first data edge stays tri-stated
    first_d = is_start(cyc_d) && !sel_q;
    dout_d  = rd_q ? mem[rd_addr_q] : DQ_OUT;
    // oe is seen through the two-flop synchroniser, so DQ_OE follows it three clocks late
    oe_d    = rd_q && !first_q && !oe_n_s_q && sel_d
           && !is_write(cyc_d) && (cyc_d != CYC_DESELECT)
           && (cyc_d != CYC_SLEEP);
  end

  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      rd_q         <= 1'b0;
      first_q      <= 1'b0;
      rd_addr_q    <= '0;
      DQ_OUT       <= '0;
      DQ_OE        <= 1'b0;
      CYCLE_TYPE   <= CYC_IDLE;
      SLEEP_ACTIVE <= 1'b0;
    end
    else if (CLK_EN)
    begin
      rd_q         <= rd_d;
      first_q      <= first_d;
      rd_addr_q    <= eff_addr;
      DQ_OUT       <= dout_d;
      DQ_OE        <= oe_d;
      CYCLE_TYPE   <= cyc_d;
      SLEEP_ACTIVE <= sleep_s_q;
    end
  end

  // --------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------
  sequence s_fresh_read;
    CLK_EN && cyc_d == CYC_READ_START && !sel_q;
  endsequence

  sequence s_data_edge;
    CLK_EN;
  endsequence

  property p_deselect;
    @(posedge SYS_CLK) disable iff (RST)
    CLK_EN && cyc_d == CYC_DESELECT |=> !DQ_OE && !sel_q;
  endproperty
  a_deselect: assert property (p_deselect)
    else $error("deselect did not tri-state");

  property p_sleep;
    @(posedge SYS_CLK) disable iff (RST)
    CLK_EN && sleep_s_q |=> SLEEP_ACTIVE && !DQ_OE
      && CYCLE_TYPE == CYC_SLEEP;
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("sleep not entered");

  property p_processor_addr_strobe_n_read;
    @(posedge SYS_CLK) disable iff (RST)
    CLK_EN && !sleep_s_q && !PROCESSOR_ADDR_STROBE_N && sel_now
      |=> CYCLE_TYPE == CYC_READ_START && sel_q;
  endproperty
  a_processor_addr_strobe_n_read: assert property (p_processor_addr_strobe_n_read)
    else $error("processor strobe did not start a read");

  property p_controller_addr_strobe_n_start;
    @(posedge SYS_CLK) disable iff (RST)
    CLK_EN && !sleep_s_q && PROCESSOR_ADDR_STROBE_N
      && !CONTROLLER_ADDR_STROBE_N && sel_now
      |=> CYCLE_TYPE == ($past(wr_now) ? CYC_WRITE_START : CYC_READ_START);
  endproperty
  a_controller_addr_strobe_n_start: assert property (p_controller_addr_strobe_n_start)
    else $error("controller strobe start decoded wrongly");

  property p_continue;
    @(posedge SYS_CLK) disable iff (RST)
    CLK_EN && !sleep_s_q && PROCESSOR_ADDR_STROBE_N
      && CONTROLLER_ADDR_STROBE_N && sel_q && !BURST_ADVANCE_N
      |=> CYCLE_TYPE == ($past(wr_now) ? CYC_WRITE_NEXT : CYC_READ_NEXT);
  endproperty
  a_continue: assert property (p_continue)
    else $error("burst continue decoded wrongly");

  property p_hold;
    @(posedge SYS_CLK) disable iff (RST)
    CLK_EN && (cyc_d == CYC_READ_HOLD || cyc_d == CYC_WRITE_HOLD)
      |=> rd_addr_q == $past(rd_addr_q) || !$past(CLK_EN);
  endproperty
  a_hold: assert property (p_hold)
    else $error("suspend moved the burst address");

  property p_write_off;
    @(posedge SYS_CLK) disable iff (RST)
    CLK_EN && is_write(cyc_d) |=> !DQ_OE;
  endproperty
  a_write_off: assert property (p_write_off)
    else $error("data driven during a write");

  property p_read_oe;
    @(posedge SYS_CLK) disable iff (RST)
    CLK_EN && oe_n_s_q |=> !DQ_OE;
  endproperty
  a_read_oe: assert property (p_read_oe)
    else $error("data driven with output enable high");

  property p_first_off;
    @(posedge SYS_CLK) disable iff (RST)
    s_fresh_read ##1 s_data_edge |=> !DQ_OE;
  endproperty
  a_first_off: assert property (p_first_off)
    else $error("first access after deselect drove data");

  property p_latched_sel;
    @(posedge SYS_CLK) disable iff (RST)
    CLK_EN && !is_start(cyc_d) && cyc_d != CYC_DESELECT
      && cyc_d != CYC_SLEEP |=> sel_q == $past(sel_q);
  endproperty
  a_latched_sel: assert property (p_latched_sel)
    else $error("select changed outside a strobe cycle");

endmodule : sram_bus_ctrl

`default_nettype wire

// ==== sram_bus_defs.svh ====
`ifndef SRAM_BUS_DEFS_SVH
`define SRAM_BUS_DEFS_SVH

// ----------------------------------------------------------------------
// data lane layout: eight data bits and one parity bit per lane
// ----------------------------------------------------------------------
`define LANE_W        9
`define PARITY_BIT    8
`define LANES_DEF     4
`define ADDR_W_DEF    8
`define BURST_W       2

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define SYNC_RST      1'b0
`define OE_N_SYNC_RST 1'b1
`define BURST_RST     2'h0

`endif

// ==== sram_bus_pkg.sv ====
// ----------------------------------------------------------------------
// bus cycle types
// ----------------------------------------------------------------------
package sram_bus_pkg;

  typedef enum logic [3:0] {
    CYC_IDLE        = 4'h0,
    CYC_DESELECT    = 4'h1,
    CYC_SLEEP       = 4'h2,
    CYC_READ_START  = 4'h3,
    CYC_WRITE_START = 4'h4,
    CYC_READ_NEXT   = 4'h5,
    CYC_WRITE_NEXT  = 4'h6,
    CYC_READ_HOLD   = 4'h7,
    CYC_WRITE_HOLD  = 4'h8
  } cycle_t;

endpackage : sram_bus_pkg

// ==== burst_if.sv ====
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------
// link between cycle decode and burst counter
// ----------------------------------------------------------------------
interface burst_if;
  logic       en;
  logic       load;
  logic       advance;
  logic       interleave;
  logic [1:0] ext_low;
  logic [1:0] eff_low;

  modport counter (input en, load, advance, interleave, ext_low,
                   output eff_low);
  modport user    (output en, load, advance, interleave, ext_low,
                   input eff_low);
endinterface : burst_if

`default_nettype wire

// ==== burst_counter.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "sram_bus_defs.svh"

module burst_counter (
  input  wire logic   SYS_CLK,
  input  wire logic   RST,
  burst_if.counter    bif
);

  logic [1:0] base_q;
  logic [1:0] base_d;
  logic [1:0] cnt_q;
  logic [1:0] cnt_d;

  // --------------------------------------------------------------------
  // burst order
  // --------------------------------------------------------------------
  function automatic logic [1:0] order(input logic [1:0] base,
                                       input logic [1:0] cnt,
                                       input logic       ilv);
    order = ilv ? (base ^ cnt) : 2'(base + cnt);
  endfunction : order

  always_comb
  begin
    base_d      = base_q;
    cnt_d       = cnt_q;
    bif.eff_low = order(base_q, cnt_q, bif.interleave);
    if (bif.load)
    begin
      base_d      = bif.ext_low;
      cnt_d       = `BURST_RST;
      bif.eff_low = bif.ext_low;
    end
    else if (bif.advance)
    begin
      cnt_d       = 2'(cnt_q + 2'h1);
      bif.eff_low = order(base_q, cnt_d, bif.interleave);
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      base_q <= `BURST_RST;
      cnt_q  <= `BURST_RST;
    end
    else if (bif.en)
    begin
      base_q <= base_d;
      cnt_q  <= cnt_d;
    end
  end

  // --------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------
  property p_wrap;
    @(posedge SYS_CLK) disable iff (RST)
    (bif.en && bif.load) ##1 (bif.en && bif.advance) [*4]
      |-> bif.eff_low == $past(bif.eff_low, 4);
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("burst counter did not wrap after four steps");

endmodule : burst_counter

`default_nettype wire

// ==== bus_master_model.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "sram_bus_defs.svh"

// ----------------------------------------------------------------------
// cache side master driving the burst bus
// ----------------------------------------------------------------------
module bus_master_model
#(
  parameter int LANES  = 4,
  parameter int ADDR_W = 8
)
(
  output var logic                     pipeline_chip_select_n,
  output var logic                     depth_select_high,
  output var logic                     depth_select_low_n,
  output var logic                     processor_addr_strobe_n,
  output var logic                     controller_addr_strobe_n,
  output var logic                     burst_advance_n,
  output var logic                     global_write_n,
  output var logic                     byte_write_enable_n,
  output var logic [LANES-1:0]         byte_lane_write_n,
  output var logic [ADDR_W-1:0]        addr,
  output var logic [LANES*`LANE_W-1:0] dq,
  output var logic                     output_enable_n
);

  // called just after a rising edge; all held until the next one
  task automatic put(input logic p_n, input logic c_n,
                     input logic [2:0] sel, input logic adv_n,
                     input logic gw_n, input logic bwe_n,
                     input logic [LANES-1:0] bw_n,
                     input logic [ADDR_W-1:0] a,
                     input logic [LANES*`LANE_W-1:0] d);
    {pipeline_chip_select_n, depth_select_high, depth_select_low_n} = sel;
    processor_addr_strobe_n  = p_n;
    controller_addr_strobe_n = c_n;
    burst_advance_n          = adv_n;
    global_write_n           = gw_n;
    byte_write_enable_n      = bwe_n;
    byte_lane_write_n        = bw_n;
    addr                     = a;
    // released data lines toggle, so stale data never looks valid
    dq = (gw_n & bwe_n) ? ~dq : d;
  endtask : put

  // raised ahead of write bursts so the device lets go of the pins
  task automatic oe(input logic v);
    output_enable_n = v;
  endtask : oe

  initial
  begin
    dq = '0;
    oe(1'b1);
    put(1'b1, 1'b1, 3'b100, 1'b1, 1'b1, 1'b1, '1, '0, '0);
  end

endmodule : bus_master_model

`default_nettype wire

// ==== pipelined_burst_sram_bus_control_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------
// bench top
// ----------------------------------------------------------------------
module pipelined_burst_sram_bus_control_tb_top;
  import sram_bus_pkg::*;

  localparam int DW = 36;
  localparam logic [2:0] ON = 3'b010;

  logic          clk = 1'b0;
  logic          rst = 1'b1;
  logic          sleep_req = 1'b0;
  logic          mode = 1'b1;
  logic          pipeline_chip_select_n, depth_select_high;
  logic          depth_select_low_n, processor_addr_strobe_n;
  logic          controller_addr_strobe_n, burst_advance_n;
  logic          global_write_n, byte_write_enable_n, output_enable_n;
  logic [3:0]    byte_lane_write_n;
  logic [7:0]    addr;
  logic [DW-1:0] dq, dq_out;
  logic          dq_oe, slp;
  cycle_t        cyc;
  logic [DW-1:0] mem [256];
  logic [4:0]    dsel [4] = '{5'h16, 5'h08, 5'h0B, 5'h13};
  logic [31:0]   seed = 32'h00000059;
  int            failures = 0;
  int            total_checks = 0;

  always #10 clk = ~clk;

  sram_bus_ctrl dut (
    .SYS_CLK(clk), .RST(rst), .CLK_EN(1'b1), .SLEEP_REQUEST(sleep_req),
    .OUTPUT_ENABLE_N(output_enable_n), .BURST_MODE(mode),
    .PIPELINE_CHIP_SELECT_N(pipeline_chip_select_n),
    .DEPTH_SELECT_HIGH(depth_select_high),
    .DEPTH_SELECT_LOW_N(depth_select_low_n),
    .PROCESSOR_ADDR_STROBE_N(processor_addr_strobe_n),
    .CONTROLLER_ADDR_STROBE_N(controller_addr_strobe_n),
    .BURST_ADVANCE_N(burst_advance_n), .GLOBAL_WRITE_N(global_write_n),
    .BYTE_WRITE_ENABLE_N(byte_write_enable_n),
    .BYTE_LANE_WRITE_N(byte_lane_write_n), .ADDR(addr), .DQ_IN(dq),
    .DQ_OUT(dq_out), .DQ_OE(dq_oe), .CYCLE_TYPE(cyc), .SLEEP_ACTIVE(slp)
  );

  bus_master_model mdl (
    .pipeline_chip_select_n, .depth_select_high, .depth_select_low_n,
    .processor_addr_strobe_n, .controller_addr_strobe_n,
    .burst_advance_n, .global_write_n, .byte_write_enable_n,
    .byte_lane_write_n, .addr, .dq, .output_enable_n
  );

  // ----------------------------------------------------------------------
  // expectation helpers
  // ----------------------------------------------------------------------
  function automatic logic [DW-1:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return {seed[3:0], seed};
  endfunction : rnd

  function automatic logic [7:0] ba(input logic [7:0] b, input int i,
                                   input logic ilv);
    logic [1:0] k;
    k = i[1:0];
    return {b[7:2], ilv ? b[1:0] ^ k : b[1:0] + k};
  endfunction : ba

  function automatic logic [DW-1:0] lanes(input logic [DW-1:0] old,
                                          input logic [DW-1:0] d,
                                          input logic [3:0] bw_n);
    logic [DW-1:0] r;
    r = old;
    for (int k = 0; k < 4; k++)
      if (!bw_n[k])
        r[9*k +: 9] = d[9*k +: 9];
    return r;
  endfunction : lanes

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk

  task automatic step(input logic p_n, input logic c_n,
                      input logic [2:0] sel, input logic adv_n,
                      input logic gw_n, input logic bwe_n,
                      input logic [3:0] bw_n, input logic [7:0] a,
                      input logic [DW-1:0] d);
    mdl.put(p_n, c_n, sel, adv_n, gw_n, bwe_n, bw_n, a, d);
    @(posedge clk);
    #1;
  endtask : step

  task automatic idle();
    step(1'b1, 1'b1, ON, 1'b1, 1'b1, 1'b1, 4'hF, 8'h00, '0);
  endtask : idle

  task automatic final_report();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : final_report

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    logic [7:0]    b, a2;
    logic [DW-1:0] d, r;
    logic [3:0]    bw;
    repeat (3) @(posedge clk);
    #1;
    chk(cyc, CYC_IDLE);
    chk(dq_oe, 1'b0);
    chk(slp, 1'b0);
    rst = 1'b0;
    repeat (3) idle();
    chk(cyc, CYC_IDLE);
    for (int m = 1; m >= 0; m--)
    begin
      mode = m[0];
      mdl.oe(1'b1);
      repeat (3) idle();
      r = rnd();
      b = r[7:0];
      d = rnd();
      step(1'b1, 1'b0, ON, 1'b1, 1'b0, 1'b1, 4'hF, b, d);
      chk(cyc, CYC_WRITE_START);
      mem[b] = d;
      // a fifth beat wraps the two-bit counter back to the start
      for (int i = 1; i < 5; i++)
      begin
        d = rnd();
        step(1'b1, 1'b1, ON, 1'b0, 1'b0, 1'b1, 4'hF, 8'h00, d);
        chk(cyc, CYC_WRITE_NEXT);
        mem[ba(b, i, m[0])] = d;
      end
      r = rnd();
      bw = r[3:0];
      d = rnd();
      step(1'b1, 1'b1, ON, 1'b1, 1'b1, 1'b0, bw, 8'h00, d);
      chk(cyc, (&bw) ? CYC_READ_HOLD : CYC_WRITE_HOLD);
      a2 = ba(b, 4, m[0]);
      mem[a2] = lanes(mem[a2], d, bw);
      mdl.oe(1'b0);
      repeat (3) idle();
      // write controls active on purpose: the strobe start must still read
      step(1'b0, 1'b1, ON, 1'b1, 1'b0, 1'b0, 4'h0, b, rnd());
      chk(cyc, CYC_READ_START);
      for (int i = 1; i < 4; i++)
      begin
        step(1'b1, 1'b1, ON, 1'b0, 1'b1, 1'b1, 4'hF, 8'h00, '0);
        chk(cyc, CYC_READ_NEXT);
        chk(dq_out, mem[ba(b, i - 1, m[0])]);
        chk(dq_oe, 1'b1);
      end
      repeat (2)
      begin
        idle();
        chk(cyc, CYC_READ_HOLD);
        chk(dq_out, mem[ba(b, 3, m[0])]);
      end
      mdl.oe(1'b1);
      repeat (3) idle();
      chk(dq_oe, 1'b0);
      mdl.oe(1'b0);
      repeat (3) idle();
      chk(dq_oe, 1'b1);
      // enable left low through the write to prove the device masks it
      r = rnd();
      a2 = r[7:0];
      step(1'b0, 1'b1, ON, 1'b1, 1'b1, 1'b1, 4'hF, a2, '0);
      d = rnd();
      step(1'b1, 1'b1, ON, 1'b1, 1'b0, 1'b1, 4'hF, 8'h00, d);
      chk(cyc, CYC_WRITE_HOLD);
      chk(dq_oe, 1'b0);
      mem[a2] = d;
      step(1'b1, 1'b0, ON, 1'b1, 1'b1, 1'b1, 4'hF, a2, '0);
      chk(cyc, CYC_READ_START);
      idle();
      chk(dq_out, mem[a2]);
    end
    for (int i = 0; i < 4; i++)
    begin
      step(dsel[i][4], dsel[i][3], dsel[i][2:0], 1'b0, 1'b0, 1'b1, 4'hF,
           8'h00, '0);
      chk(cyc, CYC_DESELECT);
      chk(dq_oe, 1'b0);
    end
    idle();
    chk(cyc, CYC_IDLE);
    step(1'b0, 1'b1, ON, 1'b1, 1'b1, 1'b1, 4'hF, b, '0);
    idle();
    chk(dq_oe, 1'b0);
    chk(dq_out, mem[b]);
    idle();
    chk(dq_oe, 1'b1);
    sleep_req = 1'b1;
    idle();
    idle();
    step(1'b1, 1'b0, ON, 1'b1, 1'b0, 1'b1, 4'hF, b, rnd());
    chk(cyc, CYC_SLEEP);
    chk(slp, 1'b1);
    chk(dq_oe, 1'b0);
    sleep_req = 1'b0;
    repeat (3) idle();
    chk(slp, 1'b0);
    chk(cyc, CYC_IDLE);
    step(1'b0, 1'b1, ON, 1'b1, 1'b1, 1'b1, 4'hF, b, '0);
    idle();
    idle();
    chk(dq_out, mem[b]);
    final_report();
  end

  // a hang counts against the run
  initial
  begin
    #100000;
    failures++;
    final_report();
  end

endmodule : pipelined_burst_sram_bus_control_tb_top

`default_nettype wire
